// >>> verilog/aux_input_pkg.sv
// Purpose: Shared constants for the auxiliary input function mapper
// Assumes: 20 MHz controller clock, Wishbone classic register bus
// Notes: Function codes, register offsets, field positions and timing counts
package aux_input_pkg;
  localparam int CLK_HZ = 20000000;
  // Qualification times in milliseconds
  localparam int FLOAT_ON_MS = 1000;
  localparam int FLOAT_OFF_MS = 30000;
  localparam int AUX_ON_MS = 1000;
  localparam int AUX_OFF_MS = 1000;
  localparam int FLOAT_ON_CYC = FLOAT_ON_MS * (CLK_HZ / 1000);
  localparam int FLOAT_OFF_CYC = FLOAT_OFF_MS * (CLK_HZ / 1000);
  localparam int AUX_ON_CYC = AUX_ON_MS * (CLK_HZ / 1000);
  localparam int AUX_OFF_CYC = AUX_OFF_MS * (CLK_HZ / 1000);

  // Function codes
  localparam logic [3:0] FN_DISABLED = 4'h0;
  localparam logic [3:0] FN_FLOAT_NO = 4'h1;
  localparam logic [3:0] FN_FLOAT_NC = 4'h2;
  localparam logic [3:0] FN_SETP_NO = 4'h3;
  localparam logic [3:0] FN_SETP_NC = 4'h4;
  localparam logic [3:0] FN_EN_NO = 4'h5;
  localparam logic [3:0] FN_EN_NC = 4'h6;
  localparam logic [3:0] FN_EN_RST_NO = 4'h7;
  localparam logic [3:0] FN_EN_RST_NC = 4'h8;
  localparam logic [3:0] FN_RST_NO = 4'h9;
  localparam logic [3:0] FN_LP_AUTO_NO = 4'hA;
  localparam logic [3:0] FN_LP_AUTO_NC = 4'hB;
  localparam logic [3:0] FN_LP_MAN_NO = 4'hC;
  localparam logic [3:0] FN_LP_MAN_NC = 4'hD;

  // Reset values of the three function code registers
  localparam logic [3:0] IN1_CODE_RST = 4'h1;
  localparam logic [3:0] IN2_CODE_RST = 4'h3;
  localparam logic [3:0] IN3_CODE_RST = 4'h5;

  // Status code presented on the indication output
  localparam logic [2:0] IND_NONE = 3'h0;
  localparam logic [2:0] IND_FLOAT = 3'h1;
  localparam logic [2:0] IND_SETPOINT = 3'h2;
  localparam logic [2:0] IND_ENABLE = 3'h3;
  localparam logic [2:0] IND_LOW_PRESS = 3'h4;

  // Register byte offsets
  localparam logic [7:0] REG_CODE1 = 8'h00;
  localparam logic [7:0] REG_CODE2 = 8'h04;
  localparam logic [7:0] REG_CODE3 = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_EN = 8'h14;
  localparam logic [7:0] REG_IRQ_CLR = 8'h18;

  // Status register fields
  localparam int ST_BLOCKED = 0;
  localparam int ST_FLOAT = 1;
  localparam int ST_SETP = 2;
  localparam int ST_DISABLE = 3;
  localparam int ST_BLK_RST = 4;
  localparam int ST_LOW_PRESS = 5;
  localparam int ST_IND_LSB = 8;
  localparam int ST_RAW_LSB = 12;

  // Interrupt event bits
  localparam int EV_FLOAT_SET = 0;
  localparam int EV_FLOAT_CLR = 1;
  localparam int EV_DISABLE = 2;
  localparam int EV_BLK_RST = 3;
  localparam int EV_WIDTH = 4;
endpackage

// >>> verilog/aux_sync2.sv
// Purpose: Two flip-flop synchroniser for asynchronous input pins
// Assumes: One clock domain, synchronous active high reset
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module aux_sync2 #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  // Shift the pins through two stages
  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;
endmodule

// >>> verilog/aux_qualifier.sv
// Purpose: Timed activation and release qualification of one level
// Assumes: Counts in clock cycles, synchronous active high reset
// Notes: Timer restarts whenever the level leaves the qualifying value
`timescale 1ns/10ps
module aux_qualifier #(
  parameter int ON_CYCLES = 20000000,
  parameter int OFF_CYCLES = 20000000,
  parameter int CNT_W = 30
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic level_in,
  output logic active_out
);
  typedef struct packed {
    logic active;
    logic [CNT_W-1:0] count;
  } qual_state_type;

  qual_state_type st_r;
  qual_state_type st_nxt;

  // Count while the level differs from the held state; restart on any bounce
  always_comb begin
    st_nxt = st_r;
    if (level_in == st_r.active) begin
      st_nxt.count = '0;
    end else if (!st_r.active && st_r.count >= CNT_W'(ON_CYCLES - 1)) begin
      st_nxt.active = 1'b1;
      st_nxt.count = '0;
    end else if (st_r.active && st_r.count >= CNT_W'(OFF_CYCLES - 1)) begin
      st_nxt.active = 1'b0;
      st_nxt.count = '0;
    end else begin
      st_nxt.count = st_r.count + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active_out = st_r.active;
endmodule

// >>> verilog/aux_input_mapper.sv
// Purpose: Maps three auxiliary digital inputs onto selectable functions
// Assumes: 20 MHz core_clk_in, synchronous reset, Wishbone classic slave
// Notes: Float function fully timed; other functions give qualified levels
`timescale 1ns/10ps
module aux_input_mapper #(
  parameter int NUM_INPUTS = 3,
  parameter int FLOAT_ON_CYCLES = aux_input_pkg::FLOAT_ON_CYC,
  parameter int FLOAT_OFF_CYCLES = aux_input_pkg::FLOAT_OFF_CYC,
  parameter int AUX_ON_CYCLES = aux_input_pkg::AUX_ON_CYC,
  parameter int AUX_OFF_CYCLES = aux_input_pkg::AUX_OFF_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic aux_input_one_in,
  input wire logic aux_input_two_in,
  input wire logic aux_input_three_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic system_block_out,
  output logic system_disable_out,
  output logic block_reset_out,
  output logic setpoint_active_out,
  output logic [2:0] setpoint_select_out,
  output logic low_pressure_out,
  output logic low_pressure_manual_out,
  output logic [2:0] status_code_out,
  output logic irq_out
);
  localparam int N = 3;
  localparam int EW = aux_input_pkg::EV_WIDTH;

  // Decoded function of one input after polarity is applied
  typedef struct packed {
    logic fl;
    logic sp;
    logic en;
    logic br;
    logic lp;
    logic lp_man;
  } fn_type;

  typedef struct packed {
    logic [N-1:0][3:0] code;
    logic [EW-1:0] irq_stat;
    logic [EW-1:0] irq_en;
    logic ack;
    logic [31:0] rdata;
    logic float_q;
    logic disable_q;
    logic brst_q;
    logic [2:0] ind;
  } map_state_type;

  map_state_type st_r;
  map_state_type st_nxt;

  logic [N-1:0] pin_raw;
  logic [N-1:0] pin_sync;
  logic [N-1:0] float_lvl;
  logic [N-1:0] float_act;
  logic [N-1:0] aux_lvl;
  logic [N-1:0] aux_act;
  fn_type [N-1:0] fn_raw;
  fn_type [N-1:0] fn_q;
  logic [N-1:0] variant_mask;
  logic float_any;
  logic disable_any;
  logic brst_any;
  logic setp_any;
  logic lp_any;
  logic lp_man_any;
  logic [2:0] setp_sel;

  // Decode a code and level into functions, polarity included
  function automatic fn_type decode_fn(input logic [3:0] code, input logic lvl);
    fn_type f;
    f = '0;
    unique case (code)
      aux_input_pkg::FN_FLOAT_NO: f.fl = lvl;
      aux_input_pkg::FN_FLOAT_NC: f.fl = !lvl;
      aux_input_pkg::FN_SETP_NO: f.sp = lvl;
      aux_input_pkg::FN_SETP_NC: f.sp = !lvl;
      aux_input_pkg::FN_EN_NO: f.en = lvl;
      aux_input_pkg::FN_EN_NC: f.en = !lvl;
      aux_input_pkg::FN_EN_RST_NO: begin
        f.en = lvl;
        f.br = lvl;
      end
      aux_input_pkg::FN_EN_RST_NC: begin
        f.en = !lvl;
        f.br = !lvl;
      end
      aux_input_pkg::FN_RST_NO: f.br = lvl;
      aux_input_pkg::FN_LP_AUTO_NO: f.lp = lvl;
      aux_input_pkg::FN_LP_AUTO_NC: f.lp = !lvl;
      aux_input_pkg::FN_LP_MAN_NO: begin
        f.lp = lvl;
        f.lp_man = lvl;
      end
      aux_input_pkg::FN_LP_MAN_NC: begin
        f.lp = !lvl;
        f.lp_man = !lvl;
      end
      default: f = '0;
    endcase
    return f;
  endfunction

  // Pins arrive from field contacts and must be synchronised
  assign pin_raw = {aux_input_three_in, aux_input_two_in, aux_input_one_in};

  aux_sync2 #(
    .WIDTH(N)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .async_in(pin_raw),
    .sync_out(pin_sync)
  );

  // Inputs beyond the fitted count are forced inactive
  assign variant_mask = (NUM_INPUTS >= 3) ? 3'h7 : ((NUM_INPUTS == 2) ? 3'h3 : 3'h1);

  // Each input is identical: decode, then qualify in time
  for (genvar i = 0; i < N; i++) begin : g_in
    assign fn_raw[i] = variant_mask[i] ? decode_fn(st_r.code[i], pin_sync[i]) : '0;
    assign float_lvl[i] = fn_raw[i].fl;
    assign aux_lvl[i] = fn_raw[i].sp | fn_raw[i].en | fn_raw[i].br | fn_raw[i].lp;

    aux_qualifier #(
      .ON_CYCLES(FLOAT_ON_CYCLES),
      .OFF_CYCLES(FLOAT_OFF_CYCLES),
      .CNT_W(30)
    ) u_float_q (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .level_in(float_lvl[i]),
      .active_out(float_act[i])
    );

    aux_qualifier #(
      .ON_CYCLES(AUX_ON_CYCLES),
      .OFF_CYCLES(AUX_OFF_CYCLES),
      .CNT_W(30)
    ) u_aux_q (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .level_in(aux_lvl[i]),
      .active_out(aux_act[i])
    );

    // Qualified functions keep the current decode, float bit cleared, while the input stands active
    assign fn_q[i] = aux_act[i] ? (fn_raw[i] & ~fn_type'(6'h20)) : '0;
  end

  // Merge functions across inputs
  always_comb begin
    float_any = |float_act;
    disable_any = 1'b0;
    brst_any = 1'b0;
    setp_any = 1'b0;
    lp_any = 1'b0;
    lp_man_any = 1'b0;
    setp_sel = '0;
    for (int k = 0; k < N; k++) begin
      disable_any = disable_any | fn_q[k].en;
      brst_any = brst_any | fn_q[k].br;
      setp_any = setp_any | fn_q[k].sp;
      lp_any = lp_any | fn_q[k].lp;
      lp_man_any = lp_man_any | fn_q[k].lp_man;
      setp_sel[k] = fn_q[k].sp;
    end
  end

  // Register file, indication, events and bus answer
  always_comb begin
    logic hit;
    logic [EW-1:0] ev;
    logic [EW-1:0] clr;
    hit = wb_cyc_in && wb_stb_in && !st_r.ack;
    ev = '0;
    clr = '0;
    st_nxt = st_r;
    st_nxt.float_q = float_any;
    st_nxt.disable_q = disable_any;
    st_nxt.brst_q = brst_any;
    // Float takes precedence, then enable, low pressure, setpoint
    if (float_any) begin
      st_nxt.ind = aux_input_pkg::IND_FLOAT;
    end else if (disable_any) begin
      st_nxt.ind = aux_input_pkg::IND_ENABLE;
    end else if (lp_any) begin
      st_nxt.ind = aux_input_pkg::IND_LOW_PRESS;
    end else if (setp_any) begin
      st_nxt.ind = aux_input_pkg::IND_SETPOINT;
    end else begin
      st_nxt.ind = aux_input_pkg::IND_NONE;
    end
    ev[aux_input_pkg::EV_FLOAT_SET] = float_any && !st_r.float_q;
    ev[aux_input_pkg::EV_FLOAT_CLR] = !float_any && st_r.float_q;
    ev[aux_input_pkg::EV_DISABLE] = disable_any && !st_r.disable_q;
    ev[aux_input_pkg::EV_BLK_RST] = brst_any && !st_r.brst_q;
    st_nxt.ack = hit;
    st_nxt.rdata = '0;
    if (hit && wb_we_in && wb_sel_in[0]) begin
      unique case (wb_adr_in)
        aux_input_pkg::REG_CODE1: st_nxt.code[0] = wb_dat_in[3:0];
        aux_input_pkg::REG_CODE2: st_nxt.code[1] = wb_dat_in[3:0];
        aux_input_pkg::REG_CODE3: st_nxt.code[2] = wb_dat_in[3:0];
        aux_input_pkg::REG_IRQ_EN: st_nxt.irq_en = wb_dat_in[EW-1:0];
        aux_input_pkg::REG_IRQ_CLR: clr = wb_dat_in[EW-1:0];
        default: clr = '0;
      endcase
    end
    if (hit && !wb_we_in) begin
      unique case (wb_adr_in)
        aux_input_pkg::REG_CODE1: st_nxt.rdata[3:0] = st_r.code[0];
        aux_input_pkg::REG_CODE2: st_nxt.rdata[3:0] = st_r.code[1];
        aux_input_pkg::REG_CODE3: st_nxt.rdata[3:0] = st_r.code[2];
        aux_input_pkg::REG_STATUS: begin
          st_nxt.rdata[aux_input_pkg::ST_BLOCKED] = st_r.float_q;
          st_nxt.rdata[aux_input_pkg::ST_FLOAT] = st_r.float_q;
          st_nxt.rdata[aux_input_pkg::ST_SETP] = setp_any;
          st_nxt.rdata[aux_input_pkg::ST_DISABLE] = st_r.disable_q;
          st_nxt.rdata[aux_input_pkg::ST_BLK_RST] = st_r.brst_q;
          st_nxt.rdata[aux_input_pkg::ST_LOW_PRESS] = lp_any;
          st_nxt.rdata[aux_input_pkg::ST_IND_LSB +: 3] = st_r.ind;
          st_nxt.rdata[aux_input_pkg::ST_RAW_LSB +: N] = pin_sync;
        end
        aux_input_pkg::REG_IRQ_STAT: st_nxt.rdata[EW-1:0] = st_r.irq_stat;
        aux_input_pkg::REG_IRQ_EN: st_nxt.rdata[EW-1:0] = st_r.irq_en;
        default: st_nxt.rdata = '0;
      endcase
    end
    // Set wins over clear
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
      st_r.code[0] <= aux_input_pkg::IN1_CODE_RST;
      st_r.code[1] <= aux_input_pkg::IN2_CODE_RST;
      st_r.code[2] <= aux_input_pkg::IN3_CODE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign wb_ack_out = st_r.ack;
  assign wb_dat_out = st_r.rdata;
  assign system_block_out = st_r.float_q;
  assign system_disable_out = st_r.disable_q;
  assign block_reset_out = st_r.brst_q;
  assign setpoint_active_out = setp_any;
  assign setpoint_select_out = setp_sel;
  assign low_pressure_out = lp_any;
  assign low_pressure_manual_out = lp_man_any;
  assign status_code_out = st_r.ind;
  assign irq_out = |(st_r.irq_stat & st_r.irq_en);
endmodule

// >>> tb/aux_contacts.sv
// Purpose: Field contact model for the three auxiliary input pins
// Assumes: Contacts change only just after a clock edge
// Notes: A bounce bit flips its contact for as long as it is held
`timescale 1ns/10ps
module aux_contacts (
  input wire logic core_clk_in,
  input wire logic [2:0] level_in,
  input wire logic [2:0] bounce_in,
  output logic [2:0] contact_out
);
  // Contact level with optional chatter
  always_ff @(posedge core_clk_in) begin
    contact_out <= level_in ^ bounce_in;
  end
endmodule

// >>> tb/aux_input_mapper_sva.sv
// Purpose: Port assertions for the auxiliary input mapper
// Assumes: One clock, synchronous active high reset
// Notes: Pin stability counters bound the float timing
`timescale 1ns/10ps
module aux_input_mapper_sva #(
  parameter int FLOAT_ON_CYCLES = 10,
  parameter int FLOAT_OFF_CYCLES = 40
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic aux_input_one_in,
  input wire logic aux_input_two_in,
  input wire logic aux_input_three_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic system_block_out,
  input wire logic system_disable_out,
  input wire logic [2:0] status_code_out,
  input wire logic irq_out
);
  logic [2:0] pins;
  logic [2:0] pin_r;
  int stab_r [3];
  logic on_ok;
  logic off_ok;
  assign pins = {aux_input_three_in, aux_input_two_in, aux_input_one_in};
  // Cycles each pin has held its level
  always_ff @(posedge core_clk_in) begin
    pin_r <= pins;
    for (int i = 0; i < 3; i++) begin
      stab_r[i] <= (rst_in || pins[i] != pin_r[i]) ? 0 : stab_r[i] + 1;
    end
  end
  assign on_ok = stab_r[0] >= FLOAT_ON_CYCLES || stab_r[1] >= FLOAT_ON_CYCLES ||
    stab_r[2] >= FLOAT_ON_CYCLES;
  assign off_ok = stab_r[0] >= FLOAT_OFF_CYCLES || stab_r[1] >= FLOAT_OFF_CYCLES ||
    stab_r[2] >= FLOAT_OFF_CYCLES;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_ack;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  a_ack_one_pulse: assert property (s_req |=> s_ack) else $error("bus ack late or long");
  a_dat_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  a_float_on_hold: assert property ($rose(system_block_out) |-> on_ok)
    else $error("block without held input");
  a_float_off_hold: assert property ($fell(system_block_out) |-> off_ok)
    else $error("block released early");
  a_block_float_code: assert property (system_block_out |->
    status_code_out == aux_input_pkg::IND_FLOAT) else $error("block without float code");
  a_float_code_block: assert property (status_code_out == aux_input_pkg::IND_FLOAT |->
    system_block_out) else $error("float code without block");
  a_disable_code: assert property (system_disable_out && !system_block_out |->
    status_code_out == aux_input_pkg::IND_ENABLE) else $error("disable without code");
  a_reset_quiet: assert property ($fell(rst_in) |-> !system_block_out && !irq_out &&
    !system_disable_out && status_code_out == aux_input_pkg::IND_NONE)
    else $error("outputs busy after reset");
endmodule
bind aux_input_mapper aux_input_mapper_sva #(
  .FLOAT_ON_CYCLES(FLOAT_ON_CYCLES), .FLOAT_OFF_CYCLES(FLOAT_OFF_CYCLES)
) aux_input_mapper_sva_i (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .aux_input_one_in(aux_input_one_in),
  .aux_input_two_in(aux_input_two_in), .aux_input_three_in(aux_input_three_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .system_block_out(system_block_out),
  .system_disable_out(system_disable_out), .status_code_out(status_code_out),
  .irq_out(irq_out)
);

// >>> tb/aux_input_mapper_bench.sv
// Purpose: Self-checking bench for the auxiliary input mapper
// Assumes: Short qualification counts, Wishbone classic master
// Notes: Disabled inputs carry random levels throughout
`timescale 1ns/10ps
module aux_input_mapper_bench;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF, wsel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [2:0] lvl = 3'h0, bnc = 3'h0, pins, ssel, st;
  logic ack, blk, dis, brst, spa, lp, lpm, irq;
  int err_count = 0;
  int check_count = 0;
  always #25 core_clk_in = ~core_clk_in;
  aux_contacts aux_contacts_i (.core_clk_in(core_clk_in), .level_in(lvl), .bounce_in(bnc),
    .contact_out(pins));
  aux_input_mapper #(.NUM_INPUTS(3), .FLOAT_ON_CYCLES(10), .FLOAT_OFF_CYCLES(40),
    .AUX_ON_CYCLES(10), .AUX_OFF_CYCLES(10)) aux_input_mapper_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .aux_input_one_in(pins[0]),
    .aux_input_two_in(pins[1]), .aux_input_three_in(pins[2]), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .system_block_out(blk), .system_disable_out(dis),
    .block_reset_out(brst), .setpoint_active_out(spa), .setpoint_select_out(ssel),
    .low_pressure_out(lp), .low_pressure_manual_out(lpm), .status_code_out(st),
    .irq_out(irq));
  task automatic end_sim;
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // Single classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    sel <= wsel;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk("bus ack", 1, 0);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  // Masked pins take the given level, the rest random noise
  task automatic drive(input logic [2:0] m, input logic [2:0] v);
    logic [2:0] r;
    r = 3'($urandom);
    @(posedge core_clk_in);
    lvl <= (r & ~m) | (v & m);
  endtask
  task automatic bounce(input int i);
    @(posedge core_clk_in);
    bnc[i] <= 1'b1;
    @(posedge core_clk_in);
    bnc[i] <= 1'b0;
  endtask
  // Expected outputs for code c on input i with function active a
  function automatic logic [11:0] model(input int c, input bit a, input int i);
    logic b, d, r, s, l, m;
    logic [2:0] sc;
    b = a && (c == 1 || c == 2);
    d = a && c >= 5 && c <= 8;
    r = a && c >= 7 && c <= 9;
    s = a && (c == 3 || c == 4);
    l = a && c >= 10 && c <= 13;
    m = l && c >= 12;
    sc = b ? aux_input_pkg::IND_FLOAT : d ? aux_input_pkg::IND_ENABLE :
      l ? aux_input_pkg::IND_LOW_PRESS : s ? aux_input_pkg::IND_SETPOINT : 3'h0;
    return {sc, 3'(s) << i, b, d, r, s, l, m};
  endfunction
  task automatic outs(input int c, input bit a, input int i);
    chk("outputs", 32'(model(c, a, i)), {20'h0, st, ssel, blk, dis, brst, spa, lp, lpm});
  endtask
  // Status word expected from the model, raw pins as driven
  task automatic status(input int c, input bit a, input int i);
    logic [11:0] m;
    logic [31:0] e;
    m = model(c, a, i);
    e = 32'h0;
    e[aux_input_pkg::ST_BLOCKED] = m[5];
    e[aux_input_pkg::ST_FLOAT] = m[5];
    e[aux_input_pkg::ST_SETP] = m[2];
    e[aux_input_pkg::ST_DISABLE] = m[4];
    e[aux_input_pkg::ST_BLK_RST] = m[3];
    e[aux_input_pkg::ST_LOW_PRESS] = m[1];
    e[aux_input_pkg::ST_IND_LSB +: 3] = m[11:9];
    e[aux_input_pkg::ST_RAW_LSB +: 3] = lvl;
    bus(0, aux_input_pkg::REG_STATUS, 0);
    chk("status", e, q);
  endtask
  task automatic codes(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
    bus(1, 8'h00, 32'(a));
    bus(1, 8'h04, 32'(b));
    bus(1, 8'h08, 32'(c));
  endtask
  initial begin
    int c, i;
    bit nc;
    logic [3:0] dflt [3];
    dflt = '{4'h1, 4'h3, 4'h5};
    void'($urandom(93715));
    wt(10);
    rst_in <= 1'b0;
    for (i = 0; i < 3; i++) begin
      bus(0, 8'(4 * i), 0);
      chk("default code", 32'(dflt[i]), q);
    end
    bus(1, 8'h1C, 32'hF);
    bus(0, 8'h1C, 0);
    chk("unmapped", 0, q);
    // A write without byte lane zero is acknowledged but ignored
    wsel = 4'hE;
    bus(1, aux_input_pkg::REG_CODE1, 32'h9);
    wsel = 4'hF;
    bus(0, aux_input_pkg::REG_CODE1, 0);
    chk("sel ignored", 32'h1, q);
    for (i = 0; i < 3; i++) begin
      c = $urandom_range(13, 1);
      bus(1, 8'(4 * i), 32'(c));
      bus(0, 8'(4 * i), 0);
      chk("code rw", 32'(c), q);
    end
    bus(1, aux_input_pkg::REG_IRQ_CLR, 32'hF);
    // Every code on a rotating input, others disabled with noise
    for (c = 1; c <= 15; c++) begin
      i = c % 3;
      nc = c inside {2, 4, 6, 8, 11, 13};
      codes(4'h0, 4'h0, 4'h0);
      drive(3'(1 << i), {3{nc}});
      wt(60);
      outs(0, 0, i);
      bus(1, 8'(4 * i), 32'(c));
      wt(20);
      outs(c, 0, i);
      drive(3'(1 << i), {3{~nc}});
      wt(20);
      outs(c, 1, i);
      status(c, 1, i);
      drive(3'(1 << i), {3{nc}});
      wt(30);
      if (c < 3) outs(c, 1, i);
      wt(30);
      outs(c, 0, i);
    end
    // Chattering float input, interrupt raise and clear
    drive(3'h1, 3'h0);
    codes(4'h1, 4'h0, 4'h0);
    bus(1, aux_input_pkg::REG_IRQ_CLR, 32'hF);
    bus(1, aux_input_pkg::REG_IRQ_EN, 32'h1);
    drive(3'h1, 3'h1);
    repeat (4) begin
      wt(6);
      bounce(0);
    end
    outs(1, 0, 0);
    wt(20);
    outs(1, 1, 0);
    chk("irq", 1, 32'(irq));
    bus(1, aux_input_pkg::REG_IRQ_CLR, 32'h1);
    wt(2);
    chk("irq cleared", 0, 32'(irq));
    drive(3'h1, 3'h0);
    wt(30);
    bounce(0);
    wt(30);
    outs(1, 1, 0);
    wt(30);
    outs(1, 0, 0);
    bus(0, aux_input_pkg::REG_IRQ_STAT, 0);
    chk("irq status", 32'h2, q);
    // Two float inputs share one fault
    drive(3'h3, 3'h0);
    codes(4'h1, 4'h1, 4'h0);
    drive(3'h3, 3'h3);
    wt(20);
    outs(1, 1, 0);
    drive(3'h3, 3'h2);
    wt(60);
    outs(1, 1, 0);
    drive(3'h3, 3'h0);
    wt(60);
    outs(1, 0, 0);
    bus(1, aux_input_pkg::REG_IRQ_EN, 32'h0);
    wt(2);
    chk("irq masked", 0, 32'(irq));
    bus(0, aux_input_pkg::REG_IRQ_STAT, 0);
    chk("irq status", 32'h3, q);
    // Mid-run reset drops the block and restores the default codes
    codes(4'h2, 4'h0, 4'h0);
    wt(20);
    outs(2, 1, 0);
    rst_in <= 1'b1;
    wt(2);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    outs(1, 0, 0);
    bus(0, aux_input_pkg::REG_CODE1, 0);
    chk("reset code", 32'h1, q);
    end_sim;
  end
  // Watchdog well beyond the expected run
  initial begin
    wt(20000);
    err_count++;
    end_sim;
  end
endmodule
